// file: shared/dbrk_pkg.sv
package dbrk_pkg;
    localparam int unsigned CLK_MHZ        = 25;
    localparam int unsigned NUM_CH         = 2;
    localparam int unsigned POST_ENTRIES   = 32;
    localparam logic [5:0]  POST_LAST      = 6'h1f;
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_STAT       = 8'h04;
    localparam logic [7:0]  OFS_IRQ_STAT   = 8'h08;
    localparam logic [7:0]  OFS_IRQ_CLR    = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_EN     = 8'h10;
    // debug_control_one fields
    localparam int unsigned CB_ARM         = 0;
    localparam int unsigned CB_CSBE        = 1;
    localparam int unsigned CB_BDT         = 2;
    localparam int unsigned CB_TAG         = 3;
    localparam int unsigned CB_TSRC        = 4;
    localparam int unsigned CB_TRACE_ALIGNMENT      = 6;
    localparam int unsigned CB_CBE         = 8;
    localparam int unsigned CB_IMM         = 10;
    localparam int unsigned CTRL_W         = 12;
    localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
    // trace_alignment codes, then the trace source none code
    localparam logic [1:0]  AL_END         = 2'h0;
    localparam logic [1:0]  AL_BEGIN       = 2'h1;
    localparam logic [1:0]  AL_MID         = 2'h2;
    localparam logic [1:0]  TSRC_NONE      = 2'h0;
    // interrupt status bits
    localparam int unsigned IRQ_W          = 3;
    localparam int unsigned IRQ_COPROC     = 0;
    localparam int unsigned IRQ_FINAL      = 1;
    localparam int unsigned IRQ_TRDONE     = 2;
    localparam logic [31:0] RD_ZERO        = 32'h0000_0000;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    typedef enum logic [2:0] {
        TR_IDLE,
        TR_RUN,
        TR_TAG,
        TR_FULL,
        TR_CNT
    } dbrk_trace_t;
endpackage

// file: shared/dbrk_req_if.sv
`timescale 1ns/1ps
interface dbrk_req_if;
    logic req;
    logic to_bdm;
    logic ack;
    logic force_brk;
    logic bdm_sel;
    modport owner (output req, output to_bdm, output ack,
                   input force_brk, input bdm_sel);
    modport holder (input req, input to_bdm, input ack,
                    output force_brk, output bdm_sel);
endinterface

// file: rtl/dbrk_hold.sv
`timescale 1ns/1ps
module dbrk_hold (
    input wire logic    core_clk,
    input wire logic    sys_rst,
    dbrk_req_if.holder  rq
);
    logic force_q;
    logic force_d;
    logic bdm_q;
    logic bdm_d;

    // set wins over ack so a request in the ack cycle survives
    assign force_d = rq.req | (force_q & ~rq.ack);
    assign bdm_d   = rq.req ? rq.to_bdm : bdm_q;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            force_q <= 1'b0;
            bdm_q   <= 1'b0;
        end
        else
        begin
            force_q <= force_d;
            bdm_q   <= bdm_d;
        end
    end

    assign rq.force_brk = force_q;
    assign rq.bdm_sel   = bdm_q;

    hold_until_ack_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        force_q && !rq.ack |=> force_q)
        else $error("break request dropped before ack");
    route_bdm_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        rq.req |=> force_q && (bdm_q == $past(rq.to_bdm)))
        else $error("break routing wrong");
    hold_ack_c: cover property (@(posedge core_clk) disable iff (sys_rst)
        force_q ##1 force_q ##1 rq.ack ##1 !force_q);
endmodule // dbrk_hold

// file: rtl/dbrk_top.sv
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module dbrk_top (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        coproc_brk_exec,
    input  wire logic        coproc_resume,
    input  wire logic        final_state_trig,
    input  wire logic        final_state_ch,
    input  wire logic        tagged_opcode_exec,
    input  wire logic        trace_buf_full,
    input  wire logic        trace_entry_stored,
    input  wire logic        restricted_mode,
    input  wire logic        cpu_brk_ack,
    output logic             cpu_force_brk,
    output logic             cpu_brk_to_bdm,
    output logic             coproc_halt,
    output logic             seq_to_state0,
    output logic             trace_active,
    output logic             trace_stop,
    output logic             trace_clear,
    output logic             irq
);
    localparam int unsigned CTRL_W_L = dbrk_pkg::CTRL_W;
    logic [CTRL_W_L-1:0] ctrl_q;

    dbrk_pkg::dbrk_trace_t st_q;
    dbrk_pkg::dbrk_trace_t st_d;
    logic [5:0]  cnt_q;
    logic [5:0]  cnt_d;
    logic        ch_q;
    logic        triggered_q;
    logic        halt_q;
    logic        seq0_q;
    logic        tstop_q;
    logic        tclr_q;
    logic        tact_q;
    logic        irq_q;
    logic [dbrk_pkg::IRQ_W-1:0] ist_q;
    logic [dbrk_pkg::IRQ_W-1:0] ien_q;
    logic [31:0] rdata_q;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;

    dbrk_req_if rq ();

    dbrk_hold u_hold (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .rq       (rq)
    );

    wire       arm     = ctrl_q[dbrk_pkg::CB_ARM];
    wire       csbe    = ctrl_q[dbrk_pkg::CB_CSBE];
    wire       bdt     = ctrl_q[dbrk_pkg::CB_BDT];
    wire       tagm    = ctrl_q[dbrk_pkg::CB_TAG];
    wire [1:0] tsrc    = ctrl_q[dbrk_pkg::CB_TSRC +: 2];
    wire [1:0] trace_alignment  = ctrl_q[dbrk_pkg::CB_TRACE_ALIGNMENT +: 2];
    wire [1:0] cbe     = ctrl_q[dbrk_pkg::CB_CBE +: 2];
    wire [1:0] imm     = ctrl_q[dbrk_pkg::CB_IMM +: 2];
    wire       session = (tsrc != dbrk_pkg::TSRC_NONE) & ~restricted_mode;

    // bus decode
    wire       acc     = hsel & hready & (htrans == dbrk_pkg::HTRANS_NONSEQ);
    wire       rd_acc  = acc & ~hwrite;
    wire       wr_acc  = acc & hwrite;
    wire       wr_ctrl = wr_pend_q & (wr_addr_q == dbrk_pkg::OFS_CTRL);
    wire       wr_iclr = wr_pend_q & (wr_addr_q == dbrk_pkg::OFS_IRQ_CLR);
    wire       wr_ien  = wr_pend_q & (wr_addr_q == dbrk_pkg::OFS_IRQ_EN);
    wire [7:0] ra      = haddr[7:0];
    wire       hi_zero = (haddr[31:8] == 24'h000000);
    wire [31:0] rd_mux =
        !hi_zero ? dbrk_pkg::RD_ZERO :
        (ra == dbrk_pkg::OFS_CTRL)     ? {20'h00000, ctrl_q} :
        (ra == dbrk_pkg::OFS_STAT)     ? {20'h00000, triggered_q, tact_q,
                                          cnt_q, 1'b0, 3'(st_q)} :
        (ra == dbrk_pkg::OFS_IRQ_STAT) ? {29'h0, ist_q} :
        (ra == dbrk_pkg::OFS_IRQ_EN)   ? {29'h0, ien_q} :
        dbrk_pkg::RD_ZERO;

    // coprocessor break path: no arm, no channel enable involved
    wire coproc_req = coproc_brk_exec & csbe & ~restricted_mode;

    // effective trigger: tagging defers to opcode execution
    wire trig_eff = tagm ? (st_q == dbrk_pkg::TR_TAG) & tagged_opcode_exec
                         : final_state_trig & (st_q != dbrk_pkg::TR_TAG);
    wire trig_ch  = tagm ? ch_q : final_state_ch;
    wire ch_cbe   = cbe[trig_ch];
    wire ch_imm   = imm[trig_ch];

    // immediate break on trigger: no session, imm bit, or end alignment
    wire now_brk  = trig_eff & ch_cbe &
                    (~session | ch_imm |
                     (trace_alignment == dbrk_pkg::AL_END));
    wire full_brk = (st_q == dbrk_pkg::TR_FULL) & trace_buf_full
                    & cbe[ch_q];
    wire cnt_done = (st_q == dbrk_pkg::TR_CNT) & trace_entry_stored
                    & (cnt_q == dbrk_pkg::POST_LAST);
    wire cnt_brk  = cnt_done & cbe[ch_q];
    wire fin_brk  = ~coproc_req & (now_brk | full_brk | cnt_brk);
    wire sess_end = (trig_eff & (ch_imm | ~session |
                     (trace_alignment == dbrk_pkg::AL_END) | (trace_alignment == 2'h3)))
                    | ((st_q == dbrk_pkg::TR_FULL) & trace_buf_full)
                    | cnt_done;

    assign rq.req    = coproc_req | fin_brk;
    assign rq.to_bdm = bdt;
    assign rq.ack    = cpu_brk_ack;

    // trace session sequencing
    always_comb
    begin
        st_d  = st_q;
        cnt_d = cnt_q;
        case (st_q)
            dbrk_pkg::TR_IDLE:
                if (arm && !restricted_mode)
                    st_d = dbrk_pkg::TR_RUN;
            dbrk_pkg::TR_RUN:
                if (final_state_trig && tagm)
                    st_d = dbrk_pkg::TR_TAG;
                else if (trig_eff && !sess_end)
                    st_d = (trace_alignment == dbrk_pkg::AL_BEGIN) ?
                           dbrk_pkg::TR_FULL : dbrk_pkg::TR_CNT;
                else if (trig_eff)
                    st_d = dbrk_pkg::TR_IDLE;
            dbrk_pkg::TR_TAG:
                if (trig_eff && !sess_end)
                    st_d = (trace_alignment == dbrk_pkg::AL_BEGIN) ?
                           dbrk_pkg::TR_FULL : dbrk_pkg::TR_CNT;
                else if (trig_eff)
                    st_d = dbrk_pkg::TR_IDLE;
            dbrk_pkg::TR_FULL:
                if (trace_buf_full)
                    st_d = dbrk_pkg::TR_IDLE;
            dbrk_pkg::TR_CNT:
                if (cnt_done)
                    st_d = dbrk_pkg::TR_IDLE;
                else if (trace_entry_stored)
                    cnt_d = cnt_q + 6'h01;
            default:
                st_d = dbrk_pkg::TR_IDLE;
        endcase
        if (st_d != dbrk_pkg::TR_CNT)
            cnt_d = 6'h00;
        // coprocessor break and restricted mode abort everything
        if (coproc_req || restricted_mode || !arm)
            st_d = dbrk_pkg::TR_IDLE;
    end

    // tracing runs before trigger for end and mid alignment
    wire tact_d = ~restricted_mode & session &
        (((st_d == dbrk_pkg::TR_RUN || st_d == dbrk_pkg::TR_TAG) &&
          trace_alignment == dbrk_pkg::AL_END) ||
         ((st_d == dbrk_pkg::TR_RUN || st_d == dbrk_pkg::TR_TAG) &&
          trace_alignment == dbrk_pkg::AL_MID) ||
         st_d == dbrk_pkg::TR_FULL || st_d == dbrk_pkg::TR_CNT);

    wire [dbrk_pkg::IRQ_W-1:0] ev;
    assign ev[dbrk_pkg::IRQ_COPROC] = coproc_req;
    assign ev[dbrk_pkg::IRQ_FINAL]  = fin_brk;
    assign ev[dbrk_pkg::IRQ_TRDONE] = sess_end & (st_q != dbrk_pkg::TR_IDLE);
    // set wins over a clear in the same cycle
    wire [dbrk_pkg::IRQ_W-1:0] ist_d =
        ev | (ist_q & ~(wr_iclr ? hwdata[dbrk_pkg::IRQ_W-1:0] : 3'h0));
    wire [CTRL_W_L-1:0] ctrl_w = hwdata[CTRL_W_L-1:0];
    // arm self-clears when the session ends or coprocessor breaks
    wire arm_clr = (sess_end & (st_q != dbrk_pkg::TR_IDLE)) | coproc_req;
    wire [CTRL_W_L-1:0] ctrl_d =
        wr_ctrl ? ctrl_w
                : (ctrl_q & ~({{(CTRL_W_L-1){1'b0}}, arm_clr}));

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ctrl_q      <= dbrk_pkg::CTRL_RST;
            st_q        <= dbrk_pkg::TR_IDLE;
            cnt_q       <= 6'h00;
            ch_q        <= 1'b0;
            triggered_q <= 1'b0;
            ist_q       <= 3'h0;
            ien_q       <= 3'h0;
            irq_q       <= 1'b0;
        end
        else
        begin
            ctrl_q      <= ctrl_d;
            st_q        <= st_d;
            cnt_q       <= cnt_d;
            ch_q        <= (final_state_trig && st_q != dbrk_pkg::TR_TAG)
                           ? final_state_ch : ch_q;
            triggered_q <= (st_d == dbrk_pkg::TR_FULL ||
                            st_d == dbrk_pkg::TR_CNT);
            ist_q       <= ist_d;
            ien_q       <= wr_ien ? hwdata[dbrk_pkg::IRQ_W-1:0] : ien_q;
            irq_q       <= |(ist_d & (wr_ien ? hwdata[dbrk_pkg::IRQ_W-1:0]
                                             : ien_q));
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            halt_q  <= 1'b0;
            seq0_q  <= 1'b0;
            tstop_q <= 1'b0;
            tclr_q  <= 1'b0;
            tact_q  <= 1'b0;
        end
        else
        begin
            // halt is the coprocessor's own default, unconditional
            halt_q  <= coproc_brk_exec | (halt_q & ~coproc_resume);
            seq0_q  <= coproc_req;
            tstop_q <= coproc_req | (trig_eff & ch_imm) |
                       (restricted_mode & tact_q);
            // begin alignment stores nothing before its trigger
            tclr_q  <= coproc_req & (trace_alignment == dbrk_pkg::AL_BEGIN)
                       & ~triggered_q;
            tact_q  <= tact_d;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rdata_q   <= dbrk_pkg::RD_ZERO;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else
        begin
            rdata_q   <= rd_acc ? rd_mux : rdata_q;
            wr_pend_q <= wr_acc & hi_zero;
            wr_addr_q <= wr_acc ? ra : wr_addr_q;
        end
    end

    // zero wait states, always OKAY
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign hrdata         = rdata_q;
    assign cpu_force_brk  = rq.force_brk;
    assign cpu_brk_to_bdm = rq.bdm_sel;
    assign coproc_halt    = halt_q;
    assign seq_to_state0  = seq0_q;
    assign trace_active   = tact_q;
    assign trace_stop     = tstop_q;
    assign trace_clear    = tclr_q;
    assign irq            = irq_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    cbrk_force_a: assert property (coproc_req
        |=> cpu_force_brk && seq_to_state0 && trace_stop
            && st_q == dbrk_pkg::TR_IDLE)
        else $error("coprocessor break did not force break");
    cbrk_empty_a: assert property (coproc_req && !triggered_q
        && trace_alignment == dbrk_pkg::AL_BEGIN |=> trace_clear)
        else $error("begin trace not emptied");
    cbrk_noarm_a: assert property (coproc_brk_exec && csbe
        && !restricted_mode && !arm |=> cpu_force_brk)
        else $error("coprocessor break needed arming");
    bdm_route_a: assert property (rq.req
        |=> cpu_brk_to_bdm == $past(bdt))
        else $error("bdm routing mismatch");
    cop_halt_a: assert property (coproc_brk_exec
        |=> coproc_halt)
        else $error("coprocessor not halted");
    tag_wait_a: assert property (st_q == dbrk_pkg::TR_TAG
        && !tagged_opcode_exec && !coproc_req |-> !fin_brk)
        else $error("tagged break before execution");
    defer_trace_a: assert property (st_q == dbrk_pkg::TR_FULL
        && !trace_buf_full |-> !full_brk)
        else $error("break before session end");
    nosess_now_a: assert property (trig_eff && !session && ch_cbe
        && !coproc_req |-> fin_brk ##1 cpu_force_brk)
        else $error("no-session break not immediate");
    imm_brk_a: assert property (trig_eff && ch_imm && !coproc_req
        |-> fin_brk == ch_cbe ##1 trace_stop)
        else $error("immediate break wrong");
    end_align_a: assert property (trig_eff && session && !ch_imm
        && trace_alignment == dbrk_pkg::AL_END && !coproc_req
        |-> fin_brk == ch_cbe)
        else $error("end alignment break wrong");
    mid_count_a: assert property (cnt_done && !coproc_req
        |-> fin_brk == cbe[ch_q] && cnt_q == dbrk_pkg::POST_LAST)
        else $error("mid alignment count wrong");
    restrict_a: assert property (restricted_mode
        |=> !trace_active && !seq_to_state0)
        else $error("restricted mode traced");
    cop_brk_c: cover property (coproc_req ##1 cpu_force_brk);
    full_brk_c: cover property (full_brk);
    mid_brk_c: cover property (cnt_brk);
    tag_brk_c: cover property (st_q == dbrk_pkg::TR_TAG ##1 fin_brk);
endmodule // dbrk_top

// file: testbench/dbrk_cpu_model.sv
`timescale 1ns/1ps
module dbrk_cpu_model (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       cpu_force_brk,
    input  wire logic [3:0] ack_dly,
    output logic            cpu_brk_ack
);
    logic [3:0] wait_q;

    // slow acks show whether the request is held or dropped early
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || !cpu_force_brk)
        begin
            wait_q      <= 4'h0;
            cpu_brk_ack <= 1'b0;
        end
        else
        begin
            wait_q      <= wait_q + 4'h1;
            cpu_brk_ack <= (wait_q == ack_dly);
        end
    end
endmodule // dbrk_cpu_model

// file: testbench/dbrk_top_tb.sv
`timescale 1ns/1ps
module dbrk_top_tb;
    logic        core_clk, sys_rst, hsel, hwrite, hready, hreadyout;
    logic        hresp, rd_ph, brk_q;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  ack_dly;
    logic        coproc_brk_exec, coproc_resume, final_state_trig;
    logic        final_state_ch, tagged_opcode_exec, trace_buf_full;
    logic        trace_entry_stored, restricted_mode, cpu_brk_ack;
    logic        cpu_force_brk, cpu_brk_to_bdm, coproc_halt;
    logic        seq_to_state0, trace_active, trace_stop, trace_clear, irq;
    int          miscompares, n_checks;
    logic        exp_bdm[$];
    logic [31:0] exp_rd[$];

    assign hready = hreadyout;

    dbrk_top u_dut (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
        .coproc_brk_exec, .coproc_resume, .final_state_trig,
        .final_state_ch, .tagged_opcode_exec, .trace_buf_full,
        .trace_entry_stored, .restricted_mode, .cpu_brk_ack,
        .cpu_force_brk, .cpu_brk_to_bdm, .coproc_halt, .seq_to_state0,
        .trace_active, .trace_stop, .trace_clear, .irq);

    dbrk_cpu_model u_cpu (.core_clk, .sys_rst, .cpu_force_brk, .ack_dly,
        .cpu_brk_ack);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // level check off the edge, then back onto the edge for driving
    task automatic lvl(ref logic s, input logic e);
        #1;
        chk({31'h0, s}, {31'h0, e});
        @(posedge core_clk);
    endtask

    task automatic hwait();
        int n;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1)
        begin
            miscompares++;
            test_done();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        htrans <= dbrk_pkg::HTRANS_NONSEQ;
        hwait();
        htrans <= 2'h0;
        hwdata <= d;
        hwait();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic fire(input int k);
        case (k)
            0: coproc_brk_exec <= 1'b1;
            1: final_state_trig <= 1'b1;
            2: trace_buf_full <= 1'b1;
            3: trace_entry_stored <= 1'b1;
            4: tagged_opcode_exec <= 1'b1;
            default: coproc_resume <= 1'b1;
        endcase
        @(posedge core_clk);
        {coproc_brk_exec, final_state_trig, trace_buf_full,
         trace_entry_stored, tagged_opcode_exec, coproc_resume} <= 6'h0;
        #1;
    endtask

    task automatic settle();
        int n;
        n = 0;
        while (cpu_force_brk !== 1'b0 && n < 40)
        begin
            @(posedge core_clk);
            n++;
        end
        if (n == 40)
        begin
            miscompares++;
            test_done();
        end
        step(2);
    endtask

    // final-state trigger; act: 0 none, 2 full, 3 entries, 4 tag
    task automatic fs_case(input logic [1:0] src, input logic [1:0] al,
                           input logic tg, cb, im, input int act);
        logic ch;
        logic b;
        ch = 1'($urandom);
        b = 1'($urandom);
        wr(dbrk_pkg::OFS_CTRL, {20'h0, 2'({1'b0, im} << ch),
           2'({1'b0, cb} << ch), al, src, tg, b, 2'h1});
        final_state_ch <= ch;
        step(2);
        if (cb)
            exp_bdm.push_back(b);
        fire(1);
        if (im)
            chk({31'h0, trace_stop}, 32'h1);
        step(2);
        if (act != 0)
        begin
            chk(32'(exp_bdm.size()), {31'h0, cb});
            if (act == 3)
            begin
                repeat (31)
                begin
                    fire(3);
                    step(1);
                end
                chk(32'(exp_bdm.size()), {31'h0, cb});
            end
            fire(act);
            step(2);
        end
        chk(32'(exp_bdm.size()), 32'h0);
        settle();
        wr(dbrk_pkg::OFS_CTRL, 32'h0);
    endtask

    always @(posedge core_clk)
    begin
        if (rd_ph)
            chk(hrdata, exp_rd.pop_front());
        if (!sys_rst && cpu_force_brk && !brk_q)
        begin
            if (exp_bdm.size() == 0)
                chk(32'h1, 32'h0);
            else
                chk({31'h0, cpu_brk_to_bdm}, {31'h0, exp_bdm.pop_front()});
        end
        brk_q <= cpu_force_brk;
        rd_ph <= !sys_rst && hsel && hready && !hwrite &&
                 htrans == dbrk_pkg::HTRANS_NONSEQ;
    end

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    initial
    begin
        #3000000;
        miscompares++;
        test_done();
    end

    initial
    begin
        {sys_rst, hsel, hwrite, rd_ph, brk_q} = 5'h10;
        {haddr, hwdata, htrans, hsize, ack_dly} = {64'h0, 2'h0, 3'h2, 4'h0};
        {coproc_brk_exec, coproc_resume, final_state_trig} = 3'h0;
        {final_state_ch, tagged_opcode_exec, trace_buf_full} = 3'h0;
        {trace_entry_stored, restricted_mode} = 2'h0;
        miscompares = 0;
        n_checks = 0;
        v = $urandom(86);
        step(8);
        sys_rst <= 1'b0;
        step(1);
        lvl(irq, 1'b0);
        rd(dbrk_pkg::OFS_CTRL, 32'h0);
        rd(dbrk_pkg::OFS_STAT, 32'h0);
        rd(dbrk_pkg::OFS_IRQ_EN, 32'h0);
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40, 32'h0);
        v = $urandom & 32'h0000_0ffe;
        wr(dbrk_pkg::OFS_CTRL, v);
        rd(dbrk_pkg::OFS_CTRL, v);
        wr(dbrk_pkg::OFS_IRQ_EN, 32'h1);
        // pass 0 armed begin-aligned, pass 1 unarmed with slow ack
        for (int b = 0; b < 2; b++)
        begin
            ack_dly <= 4'(b * 6);
            wr(dbrk_pkg::OFS_CTRL, b ? 32'h6 : 32'h53);
            step(2);
            exp_bdm.push_back(1'(b));
            fire(0);
            chk({29'h0, cpu_force_brk, seq_to_state0, coproc_halt}, 32'h7);
            if (b == 0)
                chk({30'h0, trace_stop, trace_clear}, 32'h3);
            step(4);
            lvl(cpu_force_brk, 1'(b));
            settle();
            rd(dbrk_pkg::OFS_IRQ_STAT, 32'h1);
            lvl(irq, 1'b1);
            rd(dbrk_pkg::OFS_CTRL, b ? 32'h6 : 32'h52);
            wr(dbrk_pkg::OFS_IRQ_CLR, 32'h1);
            step(1);
            lvl(irq, 1'b0);
            fire(5);
            lvl(coproc_halt, 1'b0);
        end
        wr(dbrk_pkg::OFS_CTRL, 32'h0f01);
        fire(0);
        lvl(coproc_halt, 1'b1);
        fire(5);
        restricted_mode <= 1'b1;
        wr(dbrk_pkg::OFS_CTRL, 32'h13);
        step(3);
        lvl(trace_active, 1'b0);
        fire(0);
        step(3);
        rd(dbrk_pkg::OFS_IRQ_STAT, 32'h0);
        fire(5);
        restricted_mode <= 1'b0;
        wr(dbrk_pkg::OFS_IRQ_EN, 32'h0);
        wr(dbrk_pkg::OFS_CTRL, 32'h2);
        exp_bdm.push_back(1'b0);
        fire(0);
        settle();
        lvl(irq, 1'b0);
        rd(dbrk_pkg::OFS_IRQ_STAT, 32'h1);
        wr(dbrk_pkg::OFS_IRQ_EN, 32'h1);
        step(1);
        lvl(irq, 1'b1);
        wr(dbrk_pkg::OFS_IRQ_CLR, 32'h7);
        fire(5);
        for (int c = 0; c < 2; c++)
        begin
            fs_case(2'h0, 2'h0, 1'b0, 1'(c), 1'b0, 0);
            fs_case(2'h1, 2'h0, 1'b0, 1'(c), 1'b0, 0);
            fs_case(2'h1, 2'h1, 1'b0, 1'(c), 1'b0, 2);
            fs_case(2'h1, 2'h2, 1'b0, 1'(c), 1'b0, 3);
            fs_case(2'h1, 2'(c + 1), 1'b0, 1'(c), 1'b1, 0);
            fs_case(2'h0, 2'h0, 1'b1, 1'(c), 1'b0, 4);
        end
        test_done();
    end
endmodule // dbrk_top_tb
